// ==== logic/bcd_core.v ====
/*
  Fetch, decode and flag core of an 8-bit processor with a 16-bit byte
  address space, plus an APB slave for run control and state readback.
  Assumes a byte-wide memory that answers a read one cycle after memRead.
*/
// Overview of operation
// - memory addresses are 16 bits wide, one byte per location.
// - bit 0 is the least significant bit, bit 7 the most significant.
// - instructions span one to three successive bytes, addressed by the first.
// - multi-byte data stored low byte first at the lower address.
// - direct address uses byte 2 as low half, byte 3 as high.
// - register-indirect address takes high half from first pair register.
// - immediates are 8 or 16 bits; 16-bit arrives low byte first.
// - without a branch, next fetch follows the current instruction upward.
// - direct branch loads program counter low from byte 2, high from byte 3.
// - indirect branch loads program counter from pointer pair high and low.
// - restart call jumps to eight times its three-bit field.
// - zero flag set when result is zero.
// - sign flag copies result bit 7.
// - parity flag set for even parity of the result.
// - carry flag set on carry or borrow out of the top bit.
// - auxiliary carry set on carry from bit 3 into bit 4.
// - data transfer instructions leave all five flags alone.
// - register move copies source to destination in five states.
// - load from memory via pointer pair takes seven states.
// - subtract register from accumulator, four states, updates all flags.
// - register codes 0-5 general, 6 memory via pointer, 7 accumulator.
// - subtraction is two's complement; carry means borrow occurred.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.vh"

module bcd_core #(
  parameter ADDR_W = `BCD_ADDR_W,
  parameter DATA_W = `BCD_DATA_W
) (
  input wire ref_clk,
  input wire reset_n,
  output reg [ADDR_W-1:0] memAddr,
  output reg memRead,
  input wire [DATA_W-1:0] memRdata,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg halted
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_FETCH = 6'h02;
  localparam [5:0] S_OPER = 6'h04;
  localparam [5:0] S_MEMRD = 6'h08;
  localparam [5:0] S_EXEC = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  reg [5:0] state_reg;
  reg [ADDR_W-1:0] pc_reg;
  reg [DATA_W-1:0] opcode_reg;
  reg [DATA_W-1:0] byte2_reg;
  reg opSecond_reg;
  reg [DATA_W-1:0] flags_reg;
  reg run_reg;
  reg step_reg;
  reg [3:0] stateCnt_reg;
  reg [3:0] stateTarget_reg;
  reg [31:0] instrCount_reg;

  wire isMove = opcode_reg[7:6] == `BCD_OP_MOVE_TOP;
  wire isSub = opcode_reg[7:3] == `BCD_OP_SUB_TOP;
  wire isHalt = opcode_reg == `BCD_OP_HALT;
  wire isJmp = opcode_reg == `BCD_OP_JMP;
  wire isPchl = opcode_reg == `BCD_OP_PCHL;
  wire isRst = opcode_reg[7:6] == `BCD_RST_TOP && opcode_reg[2:0] == `BCD_RST_LOW;
  wire [2:0] dstSel = opcode_reg[5:3];
  wire [2:0] srcSel = opcode_reg[2:0];
  wire moveValid = isMove && !isHalt;
  wire srcIsMem = (moveValid || isSub) && srcSel == `BCD_REG_MEM;

  wire rfWe;
  wire [2:0] rfWsel;
  wire [DATA_W-1:0] rfWdata;
  wire [DATA_W-1:0] rfRdata;
  wire [DATA_W-1:0] ptrHigh;
  wire [DATA_W-1:0] ptrLow;
  wire [DATA_W-1:0] accVal;

  // source read kicked off at decode so rfRdata is ready in execute
  bcd_reg_file #(
    .DATA_W(DATA_W)
  ) u_regs (
    .refClk(ref_clk),
    .resetN(reset_n),
    .writeEn(rfWe),
    .writeSel(rfWsel),
    .writeData(rfWdata),
    .readSel(srcSel),
    .readData(rfRdata),
    .ptrHigh(ptrHigh),
    .ptrLow(ptrLow),
    .accVal(accVal)
  );

  wire [DATA_W-1:0] operand = srcIsMem ? byte2_reg : rfRdata;
  wire [DATA_W:0] diff = {1'b0, accVal} - {1'b0, operand};
  wire [4:0] lowDiff = {1'b0, accVal[`BCD_NIB_MSB:0]} - {1'b0, operand[`BCD_NIB_MSB:0]};
  wire [DATA_W-1:0] subRes = diff[DATA_W-1:0];
  wire execDone = state_reg == S_EXEC && stateCnt_reg >= stateTarget_reg;

  assign rfWe = execDone && (moveValid || isSub);
  assign rfWsel = isSub ? `BCD_REG_ACC : dstSel;
  assign rfWdata = isSub ? subRes : operand;

  function [3:0] stateCount;
    input [DATA_W-1:0] op;
    begin
      if (op[7:6] == `BCD_OP_MOVE_TOP) begin
        stateCount = (op[2:0] == `BCD_REG_MEM) ? 4'd`BCD_ST_MOVE_MEM : 4'd`BCD_ST_MOVE;
      end else if (op[7:3] == `BCD_OP_SUB_TOP) begin
        stateCount = (op[2:0] == `BCD_REG_MEM) ? 4'd`BCD_ST_MOVE_MEM : 4'd`BCD_ST_SUB;
      end else if (op == `BCD_OP_JMP) begin
        stateCount = 4'd`BCD_ST_JMP;
      end else if (op == `BCD_OP_PCHL) begin
        stateCount = 4'd`BCD_ST_PCHL;
      end else if (op[7:6] == `BCD_RST_TOP && op[2:0] == `BCD_RST_LOW) begin
        stateCount = 4'd`BCD_ST_RST;
      end else begin
        stateCount = 4'd`BCD_ST_OTHER;
      end
    end
  endfunction

  // operand bytes after the opcode; unknown opcodes are one byte, no effect
  function [1:0] opLength;
    input [DATA_W-1:0] op;
    begin
      opLength = (op == `BCD_OP_JMP) ? 2'd2 : 2'd0;
    end
  endfunction

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      pc_reg <= `BCD_RESET_PC;
      opcode_reg <= {DATA_W{1'b0}};
      byte2_reg <= {DATA_W{1'b0}};
      opSecond_reg <= 1'b0;
      flags_reg <= {DATA_W{1'b0}};
      stateCnt_reg <= 4'd0;
      stateTarget_reg <= 4'd0;
      instrCount_reg <= 32'h00000000;
      memAddr <= {ADDR_W{1'b0}};
      memRead <= 1'b0;
      halted <= 1'b0;
    end else begin
      memRead <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (run_reg || step_reg) begin
            memAddr <= pc_reg;
            memRead <= 1'b1;
            pc_reg <= pc_reg + 16'h0001;
            halted <= 1'b0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (memRead) begin
            state_reg <= S_FETCH;
          end else begin
            opcode_reg <= memRdata;
            opSecond_reg <= 1'b0;
            stateTarget_reg <= stateCount(memRdata);
            stateCnt_reg <= 4'd1;
            if (opLength(memRdata) != 2'd0) begin
              memAddr <= pc_reg;
              memRead <= 1'b1;
              pc_reg <= pc_reg + 16'h0001;
              state_reg <= S_OPER;
            end else if (memRdata[7:6] == `BCD_OP_MOVE_TOP && memRdata[2:0] == `BCD_REG_MEM
                         && memRdata != `BCD_OP_HALT
                         || memRdata[7:3] == `BCD_OP_SUB_TOP
                         && memRdata[2:0] == `BCD_REG_MEM) begin
              memAddr <= {ptrHigh, ptrLow};
              memRead <= 1'b1;
              state_reg <= S_MEMRD;
            end else begin
              state_reg <= S_EXEC;
            end
          end
        end
        S_OPER: begin
          stateCnt_reg <= stateCnt_reg + 4'd1;
          if (!memRead) begin
            if (!opSecond_reg) begin
              byte2_reg <= memRdata; // low half first
              opSecond_reg <= 1'b1;
              memAddr <= pc_reg;
              memRead <= 1'b1;
              pc_reg <= pc_reg + 16'h0001;
            end else begin
              pc_reg <= {memRdata, byte2_reg};
              state_reg <= S_EXEC;
            end
          end
        end
        S_MEMRD: begin
          stateCnt_reg <= stateCnt_reg + 4'd1;
          if (!memRead) begin
            byte2_reg <= memRdata;
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          stateCnt_reg <= stateCnt_reg + 4'd1;
          if (execDone) begin
            instrCount_reg <= instrCount_reg + 32'h00000001;
            if (isPchl) begin
              pc_reg <= {ptrHigh, ptrLow};
            end
            if (isRst) begin
              pc_reg <= {{(ADDR_W-6){1'b0}}, opcode_reg[5:3], 3'b000};
            end
            if (isSub) begin
              // moves never reach here, so flags hold across transfers
              flags_reg[`BCD_F_ZERO] <= subRes == 8'h00;
              flags_reg[`BCD_F_SIGN] <= subRes[`BCD_MSB];
              flags_reg[`BCD_F_PARITY] <= ~^subRes;
              flags_reg[`BCD_F_CARRY] <= diff[DATA_W];
              flags_reg[`BCD_F_AUX] <= lowDiff[4];
            end
            if (isHalt) begin
              halted <= 1'b1;
            end
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // apb slave: zero-wait, unmapped reads return zero with pslverr
  wire apbAccess = psel && penable;
  wire apbMapped = paddr == `BCD_APB_CTRL || paddr == `BCD_APB_PC
                || paddr == `BCD_APB_ACC || paddr == `BCD_APB_FLAGS
                || paddr == `BCD_APB_STATUS || paddr == `BCD_APB_INSTR;
  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbMapped;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      // step is a one-shot: consumed when the idle state takes it
      if (state_reg == S_IDLE) begin
        step_reg <= 1'b0;
      end
      if (apbAccess && pwrite && paddr == `BCD_APB_CTRL) begin
        run_reg <= pwdata[`BCD_CTRL_RUN];
        if (pwdata[`BCD_CTRL_STEP]) begin
          step_reg <= 1'b1;
        end
      end
      if (isHalt && execDone) begin
        run_reg <= 1'b0;
      end
    end
  end

  always @* begin
    case (paddr)
      `BCD_APB_CTRL: prdata = {30'h00000000, step_reg, run_reg};
      `BCD_APB_PC: prdata = {16'h0000, pc_reg};
      `BCD_APB_ACC: prdata = {24'h000000, accVal};
      `BCD_APB_FLAGS: prdata = {24'h000000, flags_reg};
      `BCD_APB_STATUS: prdata = {26'h0000000, state_reg};
      `BCD_APB_INSTR: prdata = instrCount_reg;
      default: prdata = 32'h00000000;
    endcase
  end
endmodule // bcd_core

`default_nettype wire

// ==== shared/bcd_consts.vh ====
/*
  Constants for the byte processor fetch/decode/flag core: opcode fields,
  register codes, flag positions, state counts and APB register map.
  Assumes inclusion by bare name from design files.
*/
`ifndef BCD_CONSTS_VH
`define BCD_CONSTS_VH

`define BCD_ADDR_W 16
`define BCD_DATA_W 8
`define BCD_MSB 7
`define BCD_LSB 0
`define BCD_NIB_MSB 3

`define BCD_OP_MOVE_TOP 2'h1
`define BCD_OP_SUB_TOP 5'h12
`define BCD_OP_JMP 8'hC3
`define BCD_OP_PCHL 8'hE9
`define BCD_OP_HALT 8'h76
`define BCD_RST_TOP 2'h3
`define BCD_RST_LOW 3'h7
`define BCD_RST_SCALE 3

`define BCD_REG_MEM 3'h6
`define BCD_REG_ACC 3'h7
`define BCD_REG_H 3'h4
`define BCD_REG_L 3'h5

`define BCD_ST_MOVE 5
`define BCD_ST_MOVE_MEM 7
`define BCD_ST_SUB 4
`define BCD_ST_JMP 10
`define BCD_ST_PCHL 5
`define BCD_ST_RST 11
`define BCD_ST_OTHER 4

`define BCD_F_CARRY 0
`define BCD_F_PARITY 2
`define BCD_F_AUX 4
`define BCD_F_ZERO 6
`define BCD_F_SIGN 7

`define BCD_APB_CTRL 12'h000
`define BCD_APB_PC 12'h004
`define BCD_APB_ACC 12'h008
`define BCD_APB_FLAGS 12'h00C
`define BCD_APB_STATUS 12'h010
`define BCD_APB_INSTR 12'h014
`define BCD_CTRL_RUN 0
`define BCD_CTRL_STEP 1
`define BCD_RESET_PC 16'h0000

`endif

// ==== logic/bcd_reg_file.v ====
/*
  Register file of eight 8-bit slots indexed by the three-bit register code.
  Slot 6 (memory) is never written here; read data come from a register.
  Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.vh"

module bcd_reg_file #(
  parameter DATA_W = `BCD_DATA_W
) (
  input wire refClk,
  input wire resetN,
  input wire writeEn,
  input wire [2:0] writeSel,
  input wire [DATA_W-1:0] writeData,
  input wire [2:0] readSel,
  output reg [DATA_W-1:0] readData,
  output wire [DATA_W-1:0] ptrHigh,
  output wire [DATA_W-1:0] ptrLow,
  output wire [DATA_W-1:0] accVal
);
  reg [DATA_W-1:0] slot [0:7];
  integer i;

  always @(posedge refClk or negedge resetN) begin
    if (!resetN) begin
      for (i = 0; i < 8; i = i + 1) begin
        slot[i] <= {DATA_W{1'b0}};
      end
      readData <= {DATA_W{1'b0}};
    end else begin
      if (writeEn && writeSel != `BCD_REG_MEM) begin
        slot[writeSel] <= writeData;
      end
      readData <= slot[readSel];
    end
  end

  assign ptrHigh = slot[`BCD_REG_H];
  assign ptrLow = slot[`BCD_REG_L];
  assign accVal = slot[`BCD_REG_ACC];
endmodule // bcd_reg_file

`default_nettype wire

// ==== tb/bcd_core_chk.sv ====
/* port checker for bcd_core.
   assumes the design's ports as declared; bound at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.vh"
module bcd_core_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic halted
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic startedReg;
  wire apbAcc = psel && penable;
  // no fetch may appear before software first sets run or step
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) startedReg <= 1'b0;
    else if (apbAcc && pwrite && paddr == `BCD_APB_CTRL && pwdata[1:0] != 2'h0) startedReg <= 1'b1;
  read_pulse_a: assert property (memRead |=> !memRead)
    else $error("read strobe held past one cycle");
  addr_hold_a: assert property (!memRead |-> $stable(memAddr))
    else $error("address moved with no read");
  idle_quiet_a: assert property (!startedReg |-> !memRead)
    else $error("fetch before run");
  halt_quiet_a: assert property (halted |-> !memRead)
    else $error("fetch while halted");
  ready_high_a: assert property (pready)
    else $error("ready low");
  err_access_a: assert property (pslverr |-> apbAcc)
    else $error("error outside access");
  err_zero_a: assert property (apbAcc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  map_ok_a: assert property (apbAcc && paddr inside {12'h000, 12'h004, 12'h008, 12'h00C,
      12'h010, 12'h014} |-> !pslverr)
    else $error("mapped access refused");
endmodule // bcd_core_chk
bind bcd_core bcd_core_chk chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .memAddr(memAddr),
  .memRead(memRead), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halted(halted));
`default_nettype wire

// ==== tb/bcd_mem_model.sv ====
/* byte-wide memory partner: data valid the cycle after a read strobe.
   assumes the bench fills the array by hierarchical writes. */
`timescale 1ns/1ps
`default_nettype none
module bcd_mem_model (
  input wire logic ref_clk,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:65535];
  initial begin
    memRdata = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // toggles when idle so stale data never passes for a fresh byte
  always @(posedge ref_clk)
    if (memRead) memRdata <= mem[memAddr];
    else memRdata <= ~memRdata;
endmodule // bcd_mem_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/* bench: small programs run through bcd_core against the memory model.
   assumes bcd_consts.vh on the include path and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "bcd_consts.vh"
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic refClk, resetN, psel, penable, pwrite, memRead, pready, pslverr, halted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] memAddr;
  logic [7:0] memRdata;
  logic [15:0] fetchQ [$];
  // a, b, acc, flags
  logic [31:0] rows [5] = '{32'h7E80FE81, 32'h55550044, 32'h10010F14, 32'h0001FF95, 32'h80017F10};
  logic [7:0] prog [7] = '{8'h6E, 8'h66, 8'h7E, 8'h65, 8'h46, 8'h90, 8'h76};
  int n_fail = 0;
  int cmp_count = 0;
  bcd_core dut_u (.ref_clk(refClk), .reset_n(resetN), .memAddr(memAddr), .memRead(memRead),
    .memRdata(memRdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halted(halted));
  bcd_mem_model mem_u (.ref_clk(refClk), .memAddr(memAddr), .memRead(memRead),
    .memRdata(memRdata));
  initial begin
    refClk = 1'b0;
    forever #2.5 refClk = ~refClk;
  end
  always @(posedge refClk)
    if (resetN && memRead === 1'b1) fetchQ.push_back(memAddr);
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge refClk);
    penable <= 1'b1;
    do begin
      @(posedge refClk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge refClk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex,
      input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHECK(nm, ex, r & m)
  endtask
  task automatic ld(input logic [15:0] a, input logic [7:0] b);
    mem_u.mem[a] = b;
  endtask
  task automatic reset_dut;
    resetN <= 1'b0;
    repeat (5) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    fetchQ.delete();
  endtask
  task automatic run_prog;
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    apb(1'b1, `BCD_APB_CTRL, 32'h1, r, e);
    while (halted !== 1'b1 && n < 500) begin
      @(posedge refClk);
      n++;
    end
    `CHECK("halted", 1'b1, halted)
  endtask
  task automatic chk_q(input logic [15:0] e [$]);
    `CHECK("fetch count", e.size(), fetchQ.size())
    foreach (e[i]) `CHECK("fetch addr", e[i], fetchQ[i])
  endtask
  task give_verdict;
    $display("counts: %0d compared, %0d failed", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hung halt wait costs at most 500 cycles per program; this is far beyond
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [31:0] r;
    logic e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset_dut();
    rd_chk(`BCD_APB_PC, 32'hFFFF, 32'h0, "pc");
    rd_chk(`BCD_APB_ACC, 32'hFF, 32'h0, "acc");
    rd_chk(`BCD_APB_FLAGS, 32'hD5, 32'h0, "flags");
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHECK("unmapped err", 1'b1, e)
    `CHECK("unmapped data", 32'h0, r)
    $display("test reset done");
    foreach (rows[i]) begin
      reset_dut();
      for (int k = 0; k < 7; k++) ld(k[15:0], prog[k]);
      ld(16'h006E, 8'h01);
      ld(16'h016E, rows[i][31:24]);
      ld(16'h6E6E, rows[i][23:16]);
      run_prog();
      rd_chk(`BCD_APB_ACC, 32'hFF, {24'h0, rows[i][15:8]}, "acc");
      rd_chk(`BCD_APB_FLAGS, 32'hD5, {24'h0, rows[i][7:0]}, "flags");
      rd_chk(`BCD_APB_PC, 32'hFFFF, 32'h7, "pc");
      chk_q('{16'h0000, 16'h0000, 16'h0001, 16'h006E, 16'h0002, 16'h016E, 16'h0003,
        16'h0004, 16'h6E6E, 16'h0005, 16'h0006});
      $display("test row %0d done", i);
    end
    // sub then only moves and branches, so the flags must survive to the halt
    reset_dut();
    ld(16'h0000, 8'h97);
    ld(16'h0001, 8'h6E);
    ld(16'h0002, 8'hC3);
    ld(16'h0003, 8'h34);
    ld(16'h0004, 8'h12);
    ld(16'h1234, 8'hE9);
    ld(16'h0097, 8'hEF);
    ld(16'h0028, 8'h76);
    run_prog();
    rd_chk(`BCD_APB_FLAGS, 32'hD5, 32'h44, "flags");
    rd_chk(`BCD_APB_PC, 32'hFFFF, 32'h29, "pc");
    chk_q('{16'h0000, 16'h0001, 16'h0000, 16'h0002, 16'h0003, 16'h0004, 16'h1234,
      16'h0097, 16'h0028});
    $display("test branch done");
    // single step from the halt: one-byte no-op at 0x29, then idle again
    apb(1'b1, `BCD_APB_CTRL, 32'h2, r, e);
    repeat (20) @(posedge refClk);
    `CHECK("halted clr", 1'b0, halted)
    rd_chk(`BCD_APB_PC, 32'hFFFF, 32'h2A, "pc");
    rd_chk(`BCD_APB_INSTR, 32'hFFFFFFFF, 32'h7, "instr");
    rd_chk(`BCD_APB_STATUS, 32'h3F, 32'h1, "status");
    rd_chk(`BCD_APB_CTRL, 32'h3, 32'h0, "ctrl");
    $display("test step done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
